// file: design/fdc_dma.sv
// four-channel transfer engine: request select, arbitration, addressing,
// block modes, half/full block pulses and request collision flags
// assumes a single-cycle register port and a transfer port acked by the fabric
`timescale 1ns/1ps
module fdc_dma #(
   parameter int NCH = fdc_pkg::NCH
) (
   input  wire logic                 CLK,
   input  wire logic                 RESET_N,
   input  wire logic [5:0]           ADDR,
   input  wire logic [15:0]          WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output logic      [15:0]          RDATA,
   input  wire logic [255:0]         EVENT_IN,
   input  wire logic [15:0]          PI_ADDR,
   output logic                      XFER_REQ,
   output logic      [1:0]           XFER_CHAN,
   output logic      [15:0]          XFER_SRAM_ADDR,
   output logic      [15:0]          XFER_PERIPH_ADDR,
   output logic                      XFER_WORD,
   output logic                      XFER_TO_PERIPH,
   input  wire logic                 XFER_ACK,
   output logic      [3:0]           HALF_IRQ,
   output logic      [3:0]           DONE_IRQ
);
   // elaboration checks: channel count and port widths are fixed by the map
   if (NCH != fdc_pkg::NCH) begin : g_bad_nch
      $error("fdc_dma serves exactly four channels");
   end
   if ($bits(ADDR) != fdc_pkg::AW || $bits(WDATA) != fdc_pkg::DW) begin : g_bad_width
      $error("fdc_dma register port widths differ from the register map");
   end

   typedef struct packed {
      fdc_pkg::fdc_st_t  st;
      logic [1:0]        act;
      logic [3:0]        en;
      logic [3:0]        word;
      logic [3:0]        to_per;
      logic [3:0]        rpt;
      logic [3:0]        ppong;
      logic [3:0]        hen;
      logic [3:0]        pp;
      logic [3:0]        half_done;
      logic [3:0]        pend;
      logic [3:0]        col;
      logic [3:0][1:0]   amode;
      logic [3:0][7:0]   sel;
      logic [3:0][15:0]  sta;
      logic [3:0][15:0]  stb;
      logic [3:0][15:0]  pad;
      logic [3:0][15:0]  len;
      logic [3:0][15:0]  cur;
      logic [3:0][15:0]  cnt;
      logic [15:0]       rdata;
      logic [15:0]       x_sram;
      logic [15:0]       x_per;
      logic              x_word;
      logic              x_to_per;
      logic [3:0]        half_irq;
      logic [3:0]        done_irq;
   } fdc_state_t;

   fdc_state_t s;
   fdc_state_t next_s;

   // data address tied to a request source; unlisted sources get none
   function automatic logic [15:0] src_pad(input logic [7:0] code, input logic to_per);
      case (code)
         fdc_pkg::SRC_CAPTURE_TWO:   src_pad = fdc_pkg::PAD_CAPTURE_TWO;
         fdc_pkg::SRC_COMPARE_TWO:   src_pad = to_per ? fdc_pkg::PAD_COMPARE_TWO_P
                                                      : fdc_pkg::PAD_COMPARE_TWO_S;
         fdc_pkg::SRC_SERIAL_ONE_RX: src_pad = fdc_pkg::PAD_SERIAL_ONE_RX;
         fdc_pkg::SRC_SERIAL_ONE_TX: src_pad = fdc_pkg::PAD_SERIAL_ONE_TX;
         default:                    src_pad = fdc_pkg::PAD_NONE;
      endcase
   endfunction : src_pad

   // start address of the current ping-pong half
   function automatic logic [15:0] start_of(input fdc_state_t x, input int c);
      start_of = (x.ppong[c] && x.pp[c]) ? x.stb[c] : x.sta[c];
   endfunction : start_of

   logic [3:0] evt;
   logic [3:0] frc;
   logic       hit;
   logic [1:0] win;
   logic [2:0] slot;
   logic [1:0] rch;
   logic       is_ch;

   // event routing, force strobes and priority pick
   always_comb begin
      slot  = ADDR[2:0];
      rch   = ADDR[4:3];
      is_ch = (ADDR[5] == 1'b0);
      hit   = 1'b0;
      win   = 2'h0;
      for (int c = 0; c < 4; c++) begin
         evt[c] = s.en[c] && EVENT_IN[s.sel[c]];
         frc[c] = WR && is_ch && (rch == 2'(c)) && (slot == fdc_pkg::SLOT_REQ)
                  && WDATA[fdc_pkg::REQ_FORCE] && s.en[c];
      end
      for (int c = 3; c >= 0; c--) begin
         if (s.pend[c]) begin
            hit = 1'b1;
            win = 2'(c);
         end
      end
   end

   // next-state logic
   always_comb begin
      logic [15:0] nc;
      logic [15:0] step;
      int          a;
      nc           = '0;
      step         = '0;
      a            = 0;
      next_s       = s;
      next_s.half_irq = '0;
      next_s.done_irq = '0;
      next_s.rdata = '0;
      // register reads
      if (RD) begin
         if (is_ch) begin
            case (slot)
               fdc_pkg::SLOT_CTRL: begin
                  next_s.rdata[fdc_pkg::CTL_EN]    = s.en[rch];
                  next_s.rdata[fdc_pkg::CTL_WORD]  = s.word[rch];
                  next_s.rdata[fdc_pkg::CTL_TOPER] = s.to_per[rch];
                  next_s.rdata[fdc_pkg::CTL_AM_LO +: 2] = s.amode[rch];
                  next_s.rdata[fdc_pkg::CTL_RPT]   = s.rpt[rch];
                  next_s.rdata[fdc_pkg::CTL_PPONG] = s.ppong[rch];
                  next_s.rdata[fdc_pkg::CTL_HEN]   = s.hen[rch];
               end
               fdc_pkg::SLOT_REQ:  next_s.rdata[7:0] = s.sel[rch];
               fdc_pkg::SLOT_STA:  next_s.rdata = s.sta[rch];
               fdc_pkg::SLOT_STB:  next_s.rdata = s.stb[rch];
               fdc_pkg::SLOT_PAD:  next_s.rdata = s.pad[rch];
               fdc_pkg::SLOT_LEN:  next_s.rdata = s.len[rch];
               fdc_pkg::SLOT_STAT: begin
                  next_s.rdata[14:0] = s.cnt[rch][14:0];
                  next_s.rdata[fdc_pkg::STAT_PP] = s.pp[rch];
               end
               default:            next_s.rdata = '0;
            endcase
         end else if (ADDR == fdc_pkg::ADDR_COLL) begin
            next_s.rdata[3:0] = s.col;
         end
      end
      // register writes
      if (WR && is_ch) begin
         case (slot)
            fdc_pkg::SLOT_CTRL: begin
               next_s.en[rch]     = WDATA[fdc_pkg::CTL_EN];
               next_s.word[rch]   = WDATA[fdc_pkg::CTL_WORD];
               next_s.to_per[rch] = WDATA[fdc_pkg::CTL_TOPER];
               next_s.amode[rch]  = WDATA[fdc_pkg::CTL_AM_LO +: 2];
               next_s.rpt[rch]    = WDATA[fdc_pkg::CTL_RPT];
               next_s.ppong[rch]  = WDATA[fdc_pkg::CTL_PPONG];
               next_s.hen[rch]    = WDATA[fdc_pkg::CTL_HEN];
               next_s.col[rch]    = 1'b0;
               next_s.pp[rch]     = 1'b0;
               next_s.cnt[rch]    = '0;
               next_s.half_done[rch] = 1'b0;
               next_s.pend[rch]   = 1'b0;
               next_s.cur[rch]    = s.sta[rch];
            end
            fdc_pkg::SLOT_REQ: begin
               next_s.sel[rch] = WDATA[7:0];
               next_s.pad[rch] = src_pad(WDATA[7:0], s.to_per[rch]);
            end
            fdc_pkg::SLOT_STA: begin
               next_s.sta[rch] = WDATA;
               if (!s.en[rch]) begin
                  next_s.cur[rch] = WDATA;
               end
            end
            fdc_pkg::SLOT_STB: next_s.stb[rch] = WDATA;
            fdc_pkg::SLOT_PAD: next_s.pad[rch] = WDATA;
            fdc_pkg::SLOT_LEN: next_s.len[rch] = WDATA;
            default: ;
         endcase
      end
      // transfer sequencing
      case (s.st)
         fdc_pkg::ST_IDLE: begin
            if (hit) begin
               a = int'(win);
               next_s.act  = win;
               next_s.pend[win] = 1'b0;
               next_s.x_per = s.pad[win];
               // size and direction held with the grant so a control write cannot move them
               next_s.x_word   = s.word[win];
               next_s.x_to_per = s.to_per[win];
               next_s.x_sram = (s.amode[win] == fdc_pkg::AM_PERIND) ? PI_ADDR
                                                                    : s.cur[win];
               next_s.st = fdc_pkg::ST_XFER;
            end
         end
         fdc_pkg::ST_XFER: begin
            if (XFER_ACK) begin
               a    = int'(s.act);
               step = s.word[a] ? fdc_pkg::STEP_WORD : fdc_pkg::STEP_BYTE;
               nc   = s.cnt[a] + 16'h0001;
               next_s.cnt[a] = nc;
               if (s.amode[a] == fdc_pkg::AM_POSTINC) begin
                  next_s.cur[a] = s.cur[a] + step;
               end else begin
                  next_s.cur[a] = s.cur[a];
               end
               if (s.hen[a] && !s.half_done[a] && (nc >= (s.len[a] >> 1))) begin
                  next_s.half_irq[a]  = 1'b1;
                  next_s.half_done[a] = 1'b1;
               end
               if (nc >= s.len[a]) begin
                  next_s.done_irq[a]  = 1'b1;
                  next_s.cnt[a]       = '0;
                  next_s.half_done[a] = 1'b0;
                  next_s.pp[a]        = s.ppong[a] ? !s.pp[a] : s.pp[a];
                  next_s.cur[a] = (s.ppong[a] && !s.pp[a]) ? s.stb[a] : s.sta[a];
                  if (!s.rpt[a]) begin
                     next_s.en[a] = 1'b0;
                  end
               end
               next_s.st = fdc_pkg::ST_IDLE;
            end
         end
         default: next_s.st = fdc_pkg::ST_IDLE;
      endcase
      // new requests latch last so an arrival on a grant is kept
      for (int c = 0; c < 4; c++) begin
         if (evt[c] || frc[c]) begin
            next_s.pend[c] = 1'b1;
         end
         if (evt[c] && frc[c]) begin
            next_s.col[c] = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from flip-flops
   assign RDATA            = s.rdata;
   assign XFER_REQ         = (s.st == fdc_pkg::ST_XFER);
   assign XFER_CHAN        = s.act;
   assign XFER_SRAM_ADDR   = s.x_sram;
   assign XFER_PERIPH_ADDR = s.x_per;
   assign XFER_WORD        = s.x_word;
   assign XFER_TO_PERIPH   = s.x_to_per;
   assign HALF_IRQ         = s.half_irq;
   assign DONE_IRQ         = s.done_irq;

endmodule : fdc_dma

// file: design/fdc_pkg.sv
// constants, field layout and types for the four-channel transfer controller
// assumes a 16-bit register port with a 6-bit word index
package fdc_pkg;
   localparam int NCH = 4;
   localparam int AW  = 6;
   localparam int DW  = 16;
   // per-channel register block: index = channel * CH_STRIDE + slot
   localparam logic [5:0] CH_STRIDE  = 6'h08;
   localparam logic [2:0] SLOT_CTRL  = 3'h0;
   localparam logic [2:0] SLOT_REQ   = 3'h1;
   localparam logic [2:0] SLOT_STA   = 3'h2;
   localparam logic [2:0] SLOT_STB   = 3'h3;
   localparam logic [2:0] SLOT_PAD   = 3'h4;
   localparam logic [2:0] SLOT_LEN   = 3'h5;
   localparam logic [2:0] SLOT_STAT  = 3'h6;
   localparam logic [5:0] ADDR_COLL  = 6'h20;
   // control, request and status register fields
   localparam int CTL_EN    = 0;
   localparam int CTL_WORD  = 1;
   localparam int CTL_TOPER = 2;
   localparam int CTL_AM_LO = 3;
   localparam int CTL_RPT   = 5;
   localparam int CTL_PPONG = 6;
   localparam int CTL_HEN   = 7;
   localparam int REQ_FORCE = 15;
   localparam int STAT_PP   = 15;
   // addressing modes
   localparam logic [1:0] AM_POSTINC = 2'h0;
   localparam logic [1:0] AM_FIXED   = 2'h1;
   localparam logic [1:0] AM_PERIND  = 2'h2;
   // address steps
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   // request source codes and their peripheral data addresses
   localparam logic [7:0]  SRC_EXT_INT_ZERO   = 8'h00;
   localparam logic [7:0]  SRC_CAPTURE_TWO    = 8'h05;
   localparam logic [7:0]  SRC_COMPARE_TWO    = 8'h06;
   localparam logic [7:0]  SRC_SERIAL_ONE_RX  = 8'h0b;
   localparam logic [7:0]  SRC_SERIAL_ONE_TX  = 8'h0c;
   localparam logic [15:0] PAD_NONE           = 16'h0000;
   localparam logic [15:0] PAD_CAPTURE_TWO    = 16'h014c;
   localparam logic [15:0] PAD_COMPARE_TWO_P  = 16'h0910;
   localparam logic [15:0] PAD_COMPARE_TWO_S  = 16'h090e;
   localparam logic [15:0] PAD_SERIAL_ONE_RX  = 16'h0226;
   localparam logic [15:0] PAD_SERIAL_ONE_TX  = 16'h0224;
   typedef enum logic [0:0] {ST_IDLE, ST_XFER} fdc_st_t;
endpackage : fdc_pkg

// file: verif/fdc_dma_assertions.sv
// port checker for the four-channel transfer controller
// assumes it is bound onto fdc_dma, one clock domain
`timescale 1ns/1ps
module fdc_dma_chk (
   input wire logic        CLK,
   input wire logic        RESET_N,
   input wire logic        RD,
   input wire logic [5:0]  ADDR,
   input wire logic [15:0] RDATA,
   input wire logic        XFER_REQ,
   input wire logic [1:0]  XFER_CHAN,
   input wire logic [15:0] XFER_SRAM_ADDR,
   input wire logic        XFER_ACK,
   input wire logic [3:0]  HALF_IRQ,
   input wire logic [3:0]  DONE_IRQ
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   wire logic acked = XFER_REQ && XFER_ACK;
   // transfer handshake
   chk_req_hold: assert property (XFER_REQ && !XFER_ACK |=> XFER_REQ &&
      $stable(XFER_CHAN) && $stable(XFER_SRAM_ADDR)) else $error("request moved before ack");
   chk_req_drop: assert property (acked |=> !XFER_REQ)
      else $error("request held after ack");
   // block pulses follow the acking edge of their channel
   chk_done_cause: assert property (|DONE_IRQ |-> $past(acked) &&
      DONE_IRQ == (4'h1 << $past(XFER_CHAN))) else $error("done pulse without its transfer");
   chk_half_cause: assert property (|HALF_IRQ |-> $past(acked) &&
      HALF_IRQ == (4'h1 << $past(XFER_CHAN))) else $error("half pulse without its transfer");
   chk_half_single: assert property (|HALF_IRQ |=> HALF_IRQ == 4'h0)
      else $error("half pulse longer than one cycle");
   // register port read data
   chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
      else $error("read data outside its cycle");
   chk_coll_upper: assert property ($past(RD) && $past(ADDR) == fdc_pkg::ADDR_COLL |->
      RDATA[15:4] == 12'h000) else $error("collision status upper bits set");
   chk_reset_quiet: assert property (!$past(RESET_N) |-> !XFER_REQ && RDATA == 16'h0000)
      else $error("outputs active after reset");
   // main scenarios
   cover property (acked && XFER_CHAN == 2'h3);
   cover property (|HALF_IRQ);
   cover property ((XFER_REQ && !XFER_ACK) [*3]);
endmodule : fdc_dma_chk

bind fdc_dma fdc_dma_chk u_chk (.CLK, .RESET_N, .RD, .ADDR, .RDATA, .XFER_REQ, .XFER_CHAN,
   .XFER_SRAM_ADDR, .XFER_ACK, .HALF_IRQ, .DONE_IRQ);

// file: verif/fdc_fabric.sv
// behavioural fabric answering the transfer requests of the controller
// assumes one clock and the request/ack contract of the transfer port
`timescale 1ns/1ps
module fdc_fabric #(
   parameter logic [15:0] PIV = 16'h3a5c
) (
   input  wire logic        CLK,
   input  wire logic        RESET_N,
   input  wire logic        XFER_REQ,
   input  wire logic        SLOW,
   output logic             XFER_ACK,
   output logic      [15:0] PI_ADDR
);
   logic [1:0] wait_cnt;
   // address the peripheral supplies to indirect channels
   assign PI_ADDR = PIV;
   // ack one cycle after the request is seen, three more when the previous ack was given while slow
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         XFER_ACK <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (XFER_ACK) begin
         XFER_ACK <= 1'b0;
         wait_cnt <= SLOW ? 2'h3 : 2'h0;
      end else if (XFER_REQ && wait_cnt == 2'h0) begin
         XFER_ACK <= 1'b1;
      end else if (XFER_REQ) begin
         wait_cnt <= wait_cnt - 2'h1;
      end
   end
endmodule : fdc_fabric

// file: verif/tb.sv
// self-checking bench for the four-channel transfer controller
// assumes fdc_dma with the fdc_fabric model on its transfer port
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD %0t got %h want %h", $time, a, b); end end
module tb;
   logic         CLK      = 1'b0;
   logic         RESET_N  = 1'b0;
   logic [5:0]   ADDR     = 6'h00;
   logic [15:0]  WDATA    = 16'h0000;
   logic         WR       = 1'b0;
   logic         RD       = 1'b0;
   logic [255:0] EVENT_IN = '0;
   logic         slow     = 1'b0;
   logic         rd_d     = 1'b0;
   logic [15:0]  RDATA, PI_ADDR, XFER_SRAM_ADDR, XFER_PERIPH_ADDR, a1, a2, a3, b3;
   logic [3:0]   HALF_IRQ, DONE_IRQ;
   logic [1:0]   XFER_CHAN;
   logic         XFER_REQ, XFER_WORD, XFER_TO_PERIPH, XFER_ACK;
   logic [35:0]  xq[$], xe, xo;
   logic [15:0]  rq[$], re;
   int           fail_count = 0, check_count = 0;
   int           hc[4] = '{0, 0, 0, 0}, dc[4] = '{0, 0, 0, 0};
   int           eh[4] = '{0, 1, 0, 3}, ed[4] = '{3, 1, 2, 2};
   localparam logic [15:0] PIV = 16'h3a5c;
   // system clock
   initial forever #5 CLK = ~CLK;
   fdc_dma dut (.CLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .EVENT_IN, .PI_ADDR,
      .XFER_REQ, .XFER_CHAN, .XFER_SRAM_ADDR, .XFER_PERIPH_ADDR, .XFER_WORD,
      .XFER_TO_PERIPH, .XFER_ACK, .HALF_IRQ, .DONE_IRQ);
   fdc_fabric #(.PIV(PIV)) u_fab (.CLK, .RESET_N, .XFER_REQ, .SLOW(slow), .XFER_ACK, .PI_ADDR);
   assign xo = {XFER_CHAN, XFER_SRAM_ADDR, XFER_PERIPH_ADDR, XFER_WORD, XFER_TO_PERIPH};
   // watcher: read data, acked transfers and block pulses against the notes
   always @(posedge CLK) begin
      rd_d <= RD;
      if (rd_d) begin
         re = rq.size() ? rq.pop_front() : 16'bx;
         `CHK(RDATA, re)
      end
      if (XFER_REQ === 1'b1 && XFER_ACK === 1'b1) begin
         xe = xq.size() ? xq.pop_front() : 36'bx;
         `CHK(xo, xe)
      end
      for (int i = 0; i < 4; i++) begin
         hc[i] += int'(HALF_IRQ[i] === 1'b1);
         dc[i] += int'(DONE_IRQ[i] === 1'b1);
      end
   end
   function automatic logic [5:0] ix(input logic [1:0] ch, input logic [2:0] s);
      return {1'b0, ch, s};
   endfunction : ix
   function automatic logic [255:0] m(input logic [7:0] c);
      return 256'h1 << c;
   endfunction : m
   task automatic complete_run;
      $display("mismatches %0d checks %0d", fail_count, check_count);
      if (fail_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // one bus cycle, optionally with events raised in the same cycle
   task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d,
                      input logic [255:0] e);
      @(posedge CLK);
      WR <= w;
      ADDR <= a;
      WDATA <= d;
      EVENT_IN <= e;
      @(posedge CLK);
      WR <= 1'b0;
      EVENT_IN <= '0;
   endtask : bus
   task automatic rd(input logic [5:0] a, input logic [15:0] x);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      rq.push_back(x);
      @(posedge CLK);
      RD <= 1'b0;
   endtask : rd
   // channel setup, enable written last
   task automatic cfg(input logic [1:0] ch, input logic [15:0] ctl, input logic [7:0] src,
                      input logic [15:0] sa, input logic [15:0] sb, input logic [15:0] len);
      bus(1'b1, ix(ch, fdc_pkg::SLOT_CTRL), ctl, '0);
      bus(1'b1, ix(ch, fdc_pkg::SLOT_STA), sa, '0);
      bus(1'b1, ix(ch, fdc_pkg::SLOT_STB), sb, '0);
      bus(1'b1, ix(ch, fdc_pkg::SLOT_LEN), len, '0);
      bus(1'b1, ix(ch, fdc_pkg::SLOT_REQ), {8'h00, src}, '0);
      bus(1'b1, ix(ch, fdc_pkg::SLOT_CTRL), ctl | 16'h0001, '0);
   endtask : cfg
   task automatic settle;
      int n = 0;
      while (xq.size() != 0 && n < 300) begin
         @(posedge CLK);
         n++;
      end
      if (xq.size() != 0) begin
         fail_count++;
         complete_run();
      end
      repeat (6) @(posedge CLK);
   endtask : settle
   // main sequence
   initial begin
      a1 = 16'($urandom(29));
      a2 = 16'($urandom);
      a3 = 16'($urandom) & 16'hfffe;
      b3 = 16'($urandom) & 16'hfffe;
      repeat (12) @(posedge CLK);
      RESET_N <= 1'b1;
      rd(fdc_pkg::ADDR_COLL, 16'h0000);
      rd(6'h3f, 16'h0000);
      cfg(2'h1, 16'h0080, fdc_pkg::SRC_SERIAL_ONE_RX, a1, 16'h0000, 16'h0004);
      cfg(2'h2, 16'h002e, fdc_pkg::SRC_SERIAL_ONE_TX, a2, 16'h0000, 16'h0002);
      rd(ix(2'h1, fdc_pkg::SLOT_PAD), fdc_pkg::PAD_SERIAL_ONE_RX);
      rd(ix(2'h2, fdc_pkg::SLOT_PAD), fdc_pkg::PAD_SERIAL_ONE_TX);
      rd(ix(2'h2, fdc_pkg::SLOT_CTRL), 16'h002f);
      rd(ix(2'h1, fdc_pkg::SLOT_REQ), {8'h00, fdc_pkg::SRC_SERIAL_ONE_RX});
      rd(ix(2'h1, fdc_pkg::SLOT_STA), a1);
      rd(ix(2'h1, fdc_pkg::SLOT_LEN), 16'h0004);
      for (int i = 0; i < 4; i++) begin
         xq.push_back({2'h1, a1 + 16'(i), fdc_pkg::PAD_SERIAL_ONE_RX, 2'b00});
         xq.push_back({2'h2, a2, fdc_pkg::PAD_SERIAL_ONE_TX, 2'b11});
         bus(1'b0, 6'h00, 16'h0000, m(fdc_pkg::SRC_SERIAL_ONE_RX) | m(fdc_pkg::SRC_SERIAL_ONE_TX));
         settle();
      end
      bus(1'b0, 6'h00, 16'h0000, m(fdc_pkg::SRC_SERIAL_ONE_RX));
      settle();
      slow <= 1'b1;
      cfg(2'h3, 16'h00e2, fdc_pkg::SRC_CAPTURE_TWO, a3, b3, 16'h0002);
      rd(ix(2'h3, fdc_pkg::SLOT_PAD), fdc_pkg::PAD_CAPTURE_TWO);
      for (int i = 0; i < 4; i++) begin
         xq.push_back({2'h3, (i < 2 ? a3 : b3) + 16'(2 * (i % 2)), fdc_pkg::PAD_CAPTURE_TWO, 2'b10});
         bus(1'b0, 6'h00, 16'h0000, m(fdc_pkg::SRC_CAPTURE_TWO));
         settle();
         if (i == 1) rd(ix(2'h3, fdc_pkg::SLOT_STAT), 16'h8000);
      end
      cfg(2'h0, 16'h0004, fdc_pkg::SRC_COMPARE_TWO, 16'h0000, 16'h0000, 16'h0001);
      rd(ix(2'h0, fdc_pkg::SLOT_PAD), fdc_pkg::PAD_COMPARE_TWO_P);
      cfg(2'h0, 16'h0000, fdc_pkg::SRC_COMPARE_TWO, 16'h0000, 16'h0000, 16'h0001);
      rd(ix(2'h0, fdc_pkg::SLOT_PAD), fdc_pkg::PAD_COMPARE_TWO_S);
      slow <= 1'b0;
      cfg(2'h0, 16'h0030, fdc_pkg::SRC_EXT_INT_ZERO, 16'h0000, 16'h0000, 16'h0001);
      rd(ix(2'h0, fdc_pkg::SLOT_PAD), fdc_pkg::PAD_NONE);
      xq.push_back({2'h0, PIV, fdc_pkg::PAD_NONE, 2'b00});
      xq.push_back({2'h3, a3, fdc_pkg::PAD_CAPTURE_TWO, 2'b10});
      bus(1'b0, 6'h00, 16'h0000, m(fdc_pkg::SRC_EXT_INT_ZERO) | m(fdc_pkg::SRC_CAPTURE_TWO));
      settle();
      rd(ix(2'h3, fdc_pkg::SLOT_STAT), 16'h0001);
      xq.push_back({2'h0, PIV, fdc_pkg::PAD_NONE, 2'b00});
      bus(1'b1, ix(2'h0, fdc_pkg::SLOT_REQ), 16'h8000, m(fdc_pkg::SRC_EXT_INT_ZERO));
      settle();
      rd(fdc_pkg::ADDR_COLL, 16'h0001);
      xq.push_back({2'h0, PIV, fdc_pkg::PAD_NONE, 2'b00});
      bus(1'b1, ix(2'h0, fdc_pkg::SLOT_REQ), 16'h8000, '0);
      settle();
      rd(fdc_pkg::ADDR_COLL, 16'h0001);
      bus(1'b1, ix(2'h0, fdc_pkg::SLOT_CTRL), 16'h0030, '0);
      rd(fdc_pkg::ADDR_COLL, 16'h0000);
      repeat (3) @(posedge CLK);
      for (int i = 0; i < 4; i++) begin
         `CHK(hc[i], eh[i])
         `CHK(dc[i], ed[i])
      end
      complete_run();
   end
endmodule : tb
